// [cpit_cfg.svh]
`ifndef CPIT_CFG_SVH
`define CPIT_CFG_SVH

// ----------------------------------------------------------------
// Byte lengths and clock-cycle costs
// ----------------------------------------------------------------
`define CPIT_LEN1 2'h1
`define CPIT_LEN2 2'h2
`define CPIT_LEN3 2'h3
`define CPIT_CYC1 4'h1
`define CPIT_CYC2 4'h2
`define CPIT_CYC3 4'h3
`define CPIT_CYC4 4'h4
`define CPIT_CYC8 4'h8

// ----------------------------------------------------------------
// Opcode field positions and low-nibble operand codes
// ----------------------------------------------------------------
`define CPIT_REG_BIT  3
`define CPIT_IND_TAG  3'h3
`define CPIT_LO_IMM   4'h4
`define CPIT_LO_DIR   4'h5
`define CPIT_LO_DSTA  4'h2
`define CPIT_LO_DSTI  4'h3
`define CPIT_LO_ROT   4'h3

// ----------------------------------------------------------------
// High-nibble opcode groups
// ----------------------------------------------------------------
`define CPIT_HI_INC   4'h0
`define CPIT_HI_DEC   4'h1
`define CPIT_HI_ADD   4'h2
`define CPIT_HI_SUM_WITH_CARRY  4'h3
`define CPIT_HI_ORL   4'h4
`define CPIT_HI_ANL   4'h5
`define CPIT_HI_XRL   4'h6
`define CPIT_HI_MOVI  4'h7
`define CPIT_HI_MOVD  4'h8
`define CPIT_HI_DIFFERENCE_WITH_BORROW  4'h9
`define CPIT_HI_MOVR  4'ha
`define CPIT_HI_CJNE  4'hb
`define CPIT_HI_DJNZ  4'hd
`define CPIT_HI_TOA   4'he
`define CPIT_HI_FROMA 4'hf
`define CPIT_HI_DIV   4'h8
`define CPIT_HI_MUL   4'ha
`define CPIT_HI_SWAP  4'hc
`define CPIT_HI_DA    4'hd
`define CPIT_HI_ZERO  4'he
`define CPIT_HI_INV   4'hf
`define CPIT_HI_RR    4'h0
`define CPIT_HI_RRC   4'h1
`define CPIT_HI_RL    4'h2
`define CPIT_HI_RLC   4'h3

// ----------------------------------------------------------------
// Whole opcodes, plus flash-move low-nibble codes
// ----------------------------------------------------------------
`define CPIT_OP_INC_DATA_POINTER_REG 8'ha3
`define CPIT_OP_NOP      8'h00
`define CPIT_OP_NOP_ALT  8'ha5
`define CPIT_OP_MOV_DD   8'h85
`define CPIT_OP_JBC      8'h10
`define CPIT_OP_JB       8'h20
`define CPIT_OP_JNB      8'h30
`define CPIT_OP_JC       8'h40
`define CPIT_OP_JNC      8'h50
`define CPIT_OP_JZ       8'h60
`define CPIT_OP_JNZ      8'h70
`define CPIT_OP_CJNE_IMM 8'hb4
`define CPIT_OP_CJNE_DIR 8'hb5
`define CPIT_OP_DJNZ_DIR 8'hd5
`define CPIT_LO_FL_DATA_POINTER_REG  4'h0
`define CPIT_FL_RI_TAG   3'h1

`endif

// [cpit_pkg.sv]
package cpit_pkg;

  typedef enum logic [3:0] {
    cls_none, cls_arith, cls_logic, cls_acc, cls_muldiv, cls_incdec,
    cls_move, cls_flash, cls_branch, cls_nop
  } cpit_class_type;

  typedef enum logic [2:0] {
    am_implied, am_reg, am_ind, am_dir, am_imm, am_data_pointer_reg
  } cpit_mode_type;

  typedef enum logic [1:0] {
    st_ready, st_busy, st_extra
  } cpit_state_type;

  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } cpit_flag_type;

  typedef struct packed {
    logic           known;
    logic [1:0]     len;
    logic [3:0]     cyc;
    cpit_class_type cls;
    cpit_mode_type  src;
    cpit_mode_type  dst;
    cpit_flag_type  flags;
    logic           cond;
  } cpit_dec_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic via_data_pointer_reg;
  } cpit_flash_type;

endpackage

// [cpit_decode.sv]
`timescale 1ns/1ps
`include "cpit_cfg.svh"

module cpit_decode
  import cpit_pkg::*;
(
  input  wire logic [7:0] opcode,  // Opcode byte
  output cpit_dec_type    dec      // Arithmetic, logic, accumulator and increment/decrement decode
);

  logic [3:0]    hi;
  logic [3:0]    lo;
  cpit_mode_type src_m;
  logic          alu_hi;
  logic          arith_hi;

  assign hi       = opcode[7:4];
  assign lo       = opcode[3:0];
  assign arith_hi = (hi == `CPIT_HI_ADD) || (hi == `CPIT_HI_SUM_WITH_CARRY) || (hi == `CPIT_HI_DIFFERENCE_WITH_BORROW);
  assign alu_hi   = arith_hi || (hi == `CPIT_HI_ANL) || (hi == `CPIT_HI_ORL)
                    || (hi == `CPIT_HI_XRL);

  // ----------------------------------------------------------------
  // Source operand mode from the low nibble
  // ----------------------------------------------------------------
  always_comb begin
    if (lo[`CPIT_REG_BIT]) begin
      src_m = am_reg;
    end else if (lo[3:1] == `CPIT_IND_TAG) begin
      src_m = am_ind;
    end else if (lo == `CPIT_LO_DIR) begin
      src_m = am_dir;
    end else if (lo == `CPIT_LO_IMM) begin
      src_m = am_imm;
    end else begin
      src_m = am_implied;
    end
  end

  // ----------------------------------------------------------------
  // Timing table
  // ----------------------------------------------------------------
  always_comb begin
    dec       = '0;
    dec.len   = `CPIT_LEN1;
    dec.cyc   = `CPIT_CYC1;
    dec.cls   = cls_none;
    dec.src   = am_implied;
    dec.dst   = am_implied;
    if (alu_hi && (src_m != am_implied)) begin
      dec.known = 1'b1;
      dec.cls   = arith_hi ? cls_arith : cls_logic;
      dec.src   = src_m;
      dec.flags = arith_hi ? 3'b111 : 3'b000;
      unique case (src_m)
        am_reg:  begin
          dec.len = `CPIT_LEN1;
          dec.cyc = `CPIT_CYC1;
        end
        am_ind:  begin
          dec.len = `CPIT_LEN1;
          dec.cyc = `CPIT_CYC2;
        end
        default: begin
          dec.len = `CPIT_LEN2;
          dec.cyc = `CPIT_CYC2;
        end
      endcase
    end else if (alu_hi && !arith_hi && (lo == `CPIT_LO_DSTA)) begin
      dec.known = 1'b1;
      dec.cls   = cls_logic;
      dec.dst   = am_dir;
      dec.len   = `CPIT_LEN2;
      dec.cyc   = `CPIT_CYC2;
    end else if (alu_hi && !arith_hi && (lo == `CPIT_LO_DSTI)) begin
      dec.known = 1'b1;
      dec.cls   = cls_logic;
      dec.src   = am_imm;
      dec.dst   = am_dir;
      dec.len   = `CPIT_LEN3;
      dec.cyc   = `CPIT_CYC3;
    end else if (lo == `CPIT_LO_IMM) begin
      dec.known = 1'b1;
      dec.cls   = cls_acc;
      unique case (hi)
        `CPIT_HI_MUL:  begin
          dec.cls   = cls_muldiv;
          dec.cyc   = `CPIT_CYC4;
          dec.flags = 3'b101;
        end
        `CPIT_HI_DIV:  begin
          dec.cls   = cls_muldiv;
          dec.cyc   = `CPIT_CYC8;
          dec.flags = 3'b101;
        end
        `CPIT_HI_DA:   dec.flags = 3'b100;
        `CPIT_HI_INC, `CPIT_HI_DEC: dec.cls = cls_incdec;
        `CPIT_HI_ZERO, `CPIT_HI_INV, `CPIT_HI_SWAP: dec.cyc = `CPIT_CYC1;
        default:       dec.known = 1'b0;
      endcase
    end else if ((lo == `CPIT_LO_ROT) && (hi <= `CPIT_HI_RLC)) begin
      dec.known = 1'b1;
      dec.cls   = cls_acc;
      dec.flags = {(hi == `CPIT_HI_RRC) || (hi == `CPIT_HI_RLC), 2'b00};
    end else if (opcode == `CPIT_OP_INC_DATA_POINTER_REG) begin
      dec.known = 1'b1;
      dec.cls   = cls_incdec;
      dec.dst   = am_data_pointer_reg;
    end else if (((hi == `CPIT_HI_INC) || (hi == `CPIT_HI_DEC))
                 && (src_m != am_implied) && (src_m != am_imm)) begin
      dec.known = 1'b1;
      dec.cls   = cls_incdec;
      dec.dst   = src_m;
      dec.len   = (src_m == am_dir) ? `CPIT_LEN2 : `CPIT_LEN1;
      dec.cyc   = (src_m == am_reg) ? `CPIT_CYC1 : `CPIT_CYC2;
    end
  end

endmodule

// [cpit_core.sv]
// How it works
// - Opcodes, addressing modes and flag effects follow the standard instruction set.
// - Sequencing counts plain clock cycles; there are no machine cycles.
// - Most instructions take one clock per program byte.
// - Conditional branches take one clock less when not taken.
// - External-data moves reach on-chip flash; no external memory bus exists.
// - Add, add-carry, subtract-borrow from a register: one byte, one clock.
// - Same operations from indirect RAM: one byte, two clocks.
// - Same operations from direct or immediate: two bytes, two clocks.
// - AND, OR, XOR into accumulator: 1/1 reg, 1/2 indirect, 2/2 direct or immediate.
// - AND, OR, XOR into direct byte: 2/2 from accumulator, 3/3 immediate.
// - Clear, invert, rotates and nibble swap of accumulator: one byte, one clock.
// - Copy into accumulator: 1/1 reg, 1/2 indirect, 2/2 direct or immediate.
// - Copy into register: 1/1 from accumulator, 2/2 direct or immediate.
// - Copy into direct: 2/2 from acc, reg, indirect; 3/3 direct or immediate.
// - Copy into indirect RAM: 1/2 from accumulator, 2/2 direct or immediate.
`timescale 1ns/1ps
`include "cpit_cfg.svh"

module cpit_core
  import cpit_pkg::*;
(
  input  wire logic       sys_clk,        // System clock
  input  wire logic       reset,          // Synchronous reset, active high
  input  wire logic       code_valid,     // Program byte offered by fetch
  input  wire logic [7:0] code_byte,      // Program byte
  output logic            code_ready,     // Program byte taken this cycle
  input  wire logic       branch_cond,    // Branch condition from execute
  output logic [7:0]      insn_opcode_q,  // Opcode of current instruction
  output logic [15:0]     insn_operand_q, // Operand bytes, first in low byte
  output cpit_dec_type    insn_info_q,    // Decoded length, timing and class
  output logic            insn_done_q,    // Instruction retired
  output logic            branch_taken_q, // Retired branch was taken
  output cpit_flash_type  flash_q         // Program store access request
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cpit_dec_type dec_alu;
  cpit_dec_type dec_all;
  logic [3:0]   hi;
  logic [3:0]   lo;
  logic         lo_ind;

  assign hi     = code_byte[7:4];
  assign lo     = code_byte[3:0];
  assign lo_ind = (lo[3:1] == `CPIT_IND_TAG);

  cpit_decode u_decode (
    .opcode (code_byte),
    .dec    (dec_alu)
  );

  always_comb begin
    dec_all = dec_alu;
    if (!dec_alu.known) begin
      dec_all.known = 1'b1;
      dec_all.cls   = cls_move;
      dec_all.len   = `CPIT_LEN2;
      dec_all.cyc   = `CPIT_CYC2;
      if ((hi == `CPIT_HI_TOA) && (lo[`CPIT_REG_BIT] || lo_ind || (lo == `CPIT_LO_DIR))) begin
        dec_all.src = lo[`CPIT_REG_BIT] ? am_reg : (lo_ind ? am_ind : am_dir);
        dec_all.len = (lo == `CPIT_LO_DIR) ? `CPIT_LEN2 : `CPIT_LEN1;
        dec_all.cyc = lo[`CPIT_REG_BIT] ? `CPIT_CYC1 : `CPIT_CYC2;
      end else if ((hi == `CPIT_HI_MOVI) && (lo == `CPIT_LO_IMM)) begin
        dec_all.src = am_imm;
      end else if ((hi == `CPIT_HI_FROMA) && lo[`CPIT_REG_BIT]) begin
        dec_all.dst = am_reg;
        dec_all.len = `CPIT_LEN1;
        dec_all.cyc = `CPIT_CYC1;
      end else if (((hi == `CPIT_HI_MOVR) || (hi == `CPIT_HI_MOVI)) && lo[`CPIT_REG_BIT]) begin
        dec_all.src = (hi == `CPIT_HI_MOVI) ? am_imm : am_dir;
        dec_all.dst = am_reg;
      end else if ((hi == `CPIT_HI_FROMA) && (lo == `CPIT_LO_DIR)) begin
        dec_all.dst = am_dir;
      end else if ((hi == `CPIT_HI_MOVD) && (lo[`CPIT_REG_BIT] || lo_ind)) begin
        dec_all.src = lo[`CPIT_REG_BIT] ? am_reg : am_ind;
        dec_all.dst = am_dir;
      end else if ((code_byte == `CPIT_OP_MOV_DD)
                   || ((hi == `CPIT_HI_MOVI) && (lo == `CPIT_LO_DIR))) begin
        dec_all.src = (hi == `CPIT_HI_MOVI) ? am_imm : am_dir;
        dec_all.dst = am_dir;
        dec_all.len = `CPIT_LEN3;
        dec_all.cyc = `CPIT_CYC3;
      end else if ((hi == `CPIT_HI_FROMA) && lo_ind) begin
        dec_all.dst = am_ind;
        dec_all.len = `CPIT_LEN1;
      end else if (((hi == `CPIT_HI_MOVR) || (hi == `CPIT_HI_MOVI)) && lo_ind) begin
        dec_all.src = (hi == `CPIT_HI_MOVI) ? am_imm : am_dir;
        dec_all.dst = am_ind;
      end else if (((hi == `CPIT_HI_TOA) || (hi == `CPIT_HI_FROMA))
                   && ((lo == `CPIT_LO_FL_DATA_POINTER_REG) || (lo[3:1] == `CPIT_FL_RI_TAG))) begin
        dec_all.cls = cls_flash;
        dec_all.src = (lo == `CPIT_LO_FL_DATA_POINTER_REG) ? am_data_pointer_reg : am_ind;
        dec_all.len = `CPIT_LEN1;
        dec_all.cyc = `CPIT_CYC3;
      end else if ((code_byte == `CPIT_OP_JC) || (code_byte == `CPIT_OP_JNC)
                   || (code_byte == `CPIT_OP_JZ) || (code_byte == `CPIT_OP_JNZ)
                   || ((hi == `CPIT_HI_DJNZ) && lo[`CPIT_REG_BIT])) begin
        dec_all.cls  = cls_branch;
        dec_all.cond = 1'b1;
      end else if ((code_byte == `CPIT_OP_JBC) || (code_byte == `CPIT_OP_JB)
                   || (code_byte == `CPIT_OP_JNB) || (code_byte == `CPIT_OP_CJNE_IMM)
                   || (code_byte == `CPIT_OP_CJNE_DIR) || (code_byte == `CPIT_OP_DJNZ_DIR)
                   || (hi == `CPIT_HI_CJNE && lo[`CPIT_REG_BIT])) begin
        dec_all.cls   = cls_branch;
        dec_all.cond  = 1'b1;
        dec_all.len   = `CPIT_LEN3;
        dec_all.cyc   = `CPIT_CYC3;
        dec_all.flags = {(hi == `CPIT_HI_CJNE), 2'b00};
      end else if ((hi == `CPIT_HI_CJNE) && lo_ind) begin
        dec_all.cls   = cls_branch;
        dec_all.cond  = 1'b1;
        dec_all.len   = `CPIT_LEN3;
        dec_all.cyc   = `CPIT_CYC4;
        dec_all.flags = 3'b100;
      end else if ((code_byte == `CPIT_OP_NOP) || (code_byte == `CPIT_OP_NOP_ALT)) begin
        dec_all.cls = cls_nop;
        dec_all.len = `CPIT_LEN1;
        dec_all.cyc = `CPIT_CYC1;
      end else begin
        // Left to the control-transfer unit; retired as a single byte here
        dec_all.known = 1'b0;
        dec_all.cls   = cls_none;
        dec_all.len   = `CPIT_LEN1;
        dec_all.cyc   = `CPIT_CYC1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  cpit_state_type state_q;
  cpit_state_type state_d;
  logic [3:0]     cnt_q;
  logic [3:0]     cnt_d;
  logic [1:0]     bytes_q;
  logic [1:0]     bytes_d;
  logic           got1_q;
  logic           got1_d;
  logic [7:0]     opcode_d;
  logic [15:0]    operand_d;
  cpit_dec_type   info_d;
  logic           done_d;
  logic           taken_d;
  cpit_flash_type flash_d;
  logic           stall;

  // Operand bytes must arrive one per clock; a missing byte freezes the count
  assign stall = (state_q == st_busy) && (bytes_q != 2'h0) && !code_valid;

  always_comb begin
    code_ready = 1'b0;
    state_d    = state_q;
    cnt_d      = cnt_q;
    bytes_d    = bytes_q;
    got1_d     = got1_q;
    opcode_d   = insn_opcode_q;
    operand_d  = insn_operand_q;
    info_d     = insn_info_q;
    done_d     = 1'b0;
    taken_d    = 1'b0;
    flash_d    = '0;
    unique case (state_q)
      st_ready: begin
        code_ready = 1'b1;
        if (code_valid) begin
          opcode_d  = code_byte;
          operand_d = '0;
          info_d    = dec_all;
          got1_d    = 1'b0;
          cnt_d     = dec_all.cyc - `CPIT_CYC1;
          bytes_d   = dec_all.len - `CPIT_LEN1;
          // Program store is the only data space these moves can reach
          flash_d.rd       = (dec_all.cls == cls_flash) && (hi == `CPIT_HI_TOA);
          flash_d.wr       = (dec_all.cls == cls_flash) && (hi == `CPIT_HI_FROMA);
          flash_d.via_data_pointer_reg = (dec_all.cls == cls_flash) && (dec_all.src == am_data_pointer_reg);
          if (dec_all.cyc == `CPIT_CYC1) begin
            done_d = 1'b1;
          end else begin
            state_d = st_busy;
          end
        end
      end
      st_busy: begin
        code_ready = (bytes_q != 2'h0);
        if (!stall) begin
          if (bytes_q != 2'h0) begin
            bytes_d = bytes_q - `CPIT_LEN1;
            got1_d  = 1'b1;
            if (got1_q) begin
              operand_d[15:8] = code_byte;
            end else begin
              operand_d[7:0] = code_byte;
            end
          end
          cnt_d = cnt_q - `CPIT_CYC1;
          if (cnt_q == `CPIT_CYC1) begin
            // Condition is read in the last not-taken clock; taken costs one more
            if (insn_info_q.cond && branch_cond) begin
              state_d = st_extra;
            end else begin
              state_d = st_ready;
              done_d  = 1'b1;
            end
          end
        end
      end
      st_extra: begin
        state_d = st_ready;
        done_d  = 1'b1;
        taken_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q        <= st_ready;
      cnt_q          <= '0;
      bytes_q        <= '0;
      got1_q         <= 1'b0;
      insn_opcode_q  <= '0;
      insn_operand_q <= '0;
      insn_info_q    <= '0;
      insn_done_q    <= 1'b0;
      branch_taken_q <= 1'b0;
      flash_q        <= '0;
    end else begin
      state_q        <= state_d;
      cnt_q          <= cnt_d;
      bytes_q        <= bytes_d;
      got1_q         <= got1_d;
      insn_opcode_q  <= opcode_d;
      insn_operand_q <= operand_d;
      insn_info_q    <= info_d;
      insn_done_q    <= done_d;
      branch_taken_q <= taken_d;
      flash_q        <= flash_d;
    end
  end

endmodule

// [cpit_core_asserts.sv]
`timescale 1ns/1ps
module cpit_core_asserts
  import cpit_pkg::*;
(
  input wire logic           sys_clk,        // System clock
  input wire logic           reset,          // Sync reset, active high
  input wire logic           code_valid,     // Byte offered
  input wire logic [7:0]     code_byte,      // Program byte
  input wire logic           code_ready,     // Byte taken
  input wire logic           branch_cond,    // Branch condition
  input wire logic [7:0]     insn_opcode_q,  // Current opcode
  input wire logic [15:0]    insn_operand_q, // Operand bytes
  input wire cpit_dec_type   insn_info_q,    // Decode info
  input wire logic           insn_done_q,    // Retire pulse
  input wire logic           branch_taken_q, // Taken pulse
  input wire cpit_flash_type flash_q         // Program store request
);
  // ----------------------------------------------------------------
  // Timing and flash checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_taken_done: assert property (branch_taken_q |-> insn_done_q && !$past(code_ready))
    else $error("taken branch without retire or extra cycle");
  a_flash_pulse: assert property ((|flash_q) |=> (flash_q == '0))
    else $error("program store request longer than one cycle");
  a_flash_read_op: assert property (flash_q.rd |-> insn_opcode_q inside {8'he0, 8'he2, 8'he3})
    else $error("program store read for wrong opcode");
  a_flash_write_op: assert property (flash_q.wr |-> insn_opcode_q inside {8'hf0, 8'hf2, 8'hf3})
    else $error("program store write for wrong opcode");
  a_single_back: assert property (insn_done_q && code_valid && code_ready
                                  && code_byte inside {8'h04, 8'he4} |=> insn_done_q)
    else $error("single cycle instruction not retired next cycle");
  a_len_eq_cyc: assert property (insn_done_q && insn_info_q.known
      && insn_info_q.cls inside {cls_arith, cls_logic, cls_move}
      && insn_info_q.src != am_ind && insn_info_q.dst != am_ind
      |-> insn_info_q.cyc == {2'h0, insn_info_q.len})
    else $error("cycle count differs from byte count");
  a_ind_arith: assert property (insn_done_q && insn_info_q.cls == cls_arith
      && insn_info_q.src == am_ind |-> insn_info_q.cyc == 4'h2 && insn_info_q.len == 2'h1)
    else $error("indirect arithmetic timing wrong");
  a_mul_cycles: assert property (insn_done_q && insn_opcode_q == 8'ha4
      |-> insn_info_q.cyc == 4'h4 && insn_info_q.len == 2'h1)
    else $error("multiply timing wrong");
  a_div_cycles: assert property (insn_done_q && insn_opcode_q == 8'h84
      |-> insn_info_q.cyc == 4'h8 && insn_info_q.len == 2'h1)
    else $error("divide timing wrong");
  a_short_operand: assert property (insn_done_q && insn_info_q.len == 2'h1
      |-> insn_operand_q == 16'h0000)
    else $error("one byte instruction holds operand bytes");

  c_taken: cover property (branch_taken_q);
  c_flash: cover property (|flash_q);
  c_back: cover property (insn_done_q ##1 insn_done_q);
endmodule

bind cpit_core cpit_core_asserts u_chk (
  .sys_clk        (sys_clk),
  .reset          (reset),
  .code_valid     (code_valid),
  .code_byte      (code_byte),
  .code_ready     (code_ready),
  .branch_cond    (branch_cond),
  .insn_opcode_q  (insn_opcode_q),
  .insn_operand_q (insn_operand_q),
  .insn_info_q    (insn_info_q),
  .insn_done_q    (insn_done_q),
  .branch_taken_q (branch_taken_q),
  .flash_q        (flash_q)
);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import cpit_pkg::*;
;
  logic           sys_clk     = 1'b0;
  logic           reset       = 1'b1;
  logic           code_valid  = 1'b0;
  logic [7:0]     code_byte   = 8'h00;
  logic           branch_cond = 1'b0;
  logic           code_ready;
  logic           insn_done_q;
  logic           branch_taken_q;
  logic [7:0]     insn_opcode_q;
  logic [15:0]    insn_operand_q;
  cpit_dec_type   insn_info_q;
  cpit_flash_type flash_q;
  int             n_fail          = 0;
  int             samples_checked = 0;
  int             cycles          = 0;

  always #10 sys_clk = ~sys_clk;

  cpit_core dut (
    .sys_clk        (sys_clk),
    .reset          (reset),
    .code_valid     (code_valid),
    .code_byte      (code_byte),
    .code_ready     (code_ready),
    .branch_cond    (branch_cond),
    .insn_opcode_q  (insn_opcode_q),
    .insn_operand_q (insn_operand_q),
    .insn_info_q    (insn_info_q),
    .insn_done_q    (insn_done_q),
    .branch_taken_q (branch_taken_q),
    .flash_q        (flash_q)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Offers opcode then operands on time; counts edges from accept to retire
  task automatic run(input logic [7:0] op, input logic [1:0] len, input logic [3:0] cyc,
                     input logic taken, input logic [2:0] fl);
    int          n;
    logic [2:0]  fl1;
    logic [15:0] opd;
    opd = 16'h0000;
    @(posedge sys_clk) #1;
    code_valid = 1'b1;
    code_byte = op;
    branch_cond = taken;
    chk("ready idle", 1, code_ready);
    @(posedge sys_clk) #1;
    n = 1;
    fl1 = flash_q;
    while (insn_done_q !== 1'b1 && n < 12) begin
      code_valid = (n < len);
      code_byte = (n == 1) ? 8'h5a : 8'hc3;
      @(posedge sys_clk) #1;
      n++;
    end
    code_valid = 1'b0;
    if (len > 2'h1) opd[7:0] = 8'h5a;
    if (len > 2'h2) opd[15:8] = 8'hc3;
    chk("retire edge", cyc + taken, n);
    chk("length", len, insn_info_q.len);
    chk("cycles", cyc, insn_info_q.cyc);
    chk("known", 1, insn_info_q.known);
    chk("taken", taken, branch_taken_q);
    chk("flash", fl, fl1);
    chk("operands", opd, insn_operand_q);
    chk("opcode", op, insn_opcode_q);
  endtask

  // ----------------------------------------------------------------
  // Scenarios; table entries are opcode, length, cycles (t_flash: opcode, request bits)
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("done", 0, insn_done_q);
    chk("info", 0, insn_info_q);
    chk("flash", 0, flash_q);
  endtask

  task automatic t_arith;
    logic [15:0] t[12] = '{16'h2811, 16'h2612, 16'h2522, 16'h2422, 16'h3811, 16'h3612,
                           16'h3522, 16'h3422, 16'h9811, 16'h9612, 16'h9522, 16'h9422};
    foreach (t[i]) begin
      run(t[i][15:8], t[i][5:4], t[i][3:0], 1'b0, 3'h0);
      chk("flags", 3'b111, insn_info_q.flags);
    end
  endtask

  task automatic t_logic;
    logic [15:0] t[18] = '{16'h5811, 16'h5612, 16'h5522, 16'h5422, 16'h5222, 16'h5333,
                           16'h4811, 16'h4612, 16'h4522, 16'h4422, 16'h4222, 16'h4333,
                           16'h6811, 16'h6612, 16'h6522, 16'h6422, 16'h6222, 16'h6333};
    foreach (t[i]) run(t[i][15:8], t[i][5:4], t[i][3:0], 1'b0, 3'h0);
  endtask

  task automatic t_acc;
    logic [15:0] t[12] = '{16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
                           16'hc411, 16'hd411, 16'ha414, 16'h8418, 16'h0011, 16'ha511};
    foreach (t[i]) run(t[i][15:8], t[i][5:4], t[i][3:0], 1'b0, 3'h0);
  endtask

  task automatic t_move;
    logic [15:0] t[15] = '{16'he811, 16'he612, 16'he522, 16'h7422, 16'hf811, 16'ha822,
                           16'h7822, 16'hf522, 16'h8822, 16'h8533, 16'h8622, 16'h7533,
                           16'hf612, 16'ha622, 16'h7622};
    foreach (t[i]) run(t[i][15:8], t[i][5:4], t[i][3:0], 1'b0, 3'h0);
  endtask

  task automatic t_incdec;
    logic [15:0] t[9] = '{16'h0411, 16'h0811, 16'h0522, 16'h0612, 16'h1411, 16'h1811,
                          16'h1522, 16'h1612, 16'ha311};
    foreach (t[i]) run(t[i][15:8], t[i][5:4], t[i][3:0], 1'b0, 3'h0);
  endtask

  // Five branches both ways: taken costs exactly one more edge
  task automatic t_branch;
    logic [15:0] t[5] = '{16'h6022, 16'h4022, 16'hd822, 16'h2033, 16'hb634};
    foreach (t[i]) begin
      run(t[i][15:8], t[i][5:4], t[i][3:0], 1'b0, 3'h0);
      run(t[i][15:8], t[i][5:4], t[i][3:0], 1'b1, 3'h0);
    end
  endtask

  // Request bits are read, write, pointer-addressed
  task automatic t_flash;
    logic [10:0] t[6] = '{11'h705, 11'h714, 11'h71c, 11'h783, 11'h792, 11'h79a};
    foreach (t[i]) run({t[i][10:6], t[i][5:3]}, 2'h1, 4'h3, 1'b0, t[i][2:0]);
  endtask

  task automatic t_back;
    @(posedge sys_clk) #1;
    code_valid = 1'b1;
    code_byte = 8'h04;
    @(posedge sys_clk) #1;
    code_byte = 8'he4;
    chk("retire first", 1, insn_done_q);
    @(posedge sys_clk) #1;
    code_valid = 1'b0;
    chk("retire second", 1, insn_done_q);
    chk("second opcode", 8'he4, insn_opcode_q);
  endtask

  // A late operand byte holds the count; a mid-run reset drops the instruction
  task automatic t_stall;
    @(posedge sys_clk) #1;
    code_valid = 1'b1;
    code_byte = 8'h24;
    @(posedge sys_clk) #1;
    code_valid = 1'b0;
    @(posedge sys_clk) #1;
    chk("stall hold", 1'h0, insn_done_q);
    chk("stall ready", 1'h1, code_ready);
    code_valid = 1'b1;
    code_byte = 8'h77;
    @(posedge sys_clk) #1;
    code_byte = 8'h84;
    chk("stall retire", 1'h1, insn_done_q);
    chk("stall operand", 16'h0077, insn_operand_q);
    @(posedge sys_clk) #1;
    code_valid = 1'b0;
    reset = 1'b1;
    @(posedge sys_clk) #1;
    reset = 1'b0;
    chk("reset ready", 1'h1, code_ready);
    chk("reset opcode", 8'h00, insn_opcode_q);
    chk("reset done", 1'h0, insn_done_q);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out;
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    #1 reset = 1'b0;
    t_reset;
    t_arith;
    t_logic;
    t_acc;
    t_move;
    t_incdec;
    t_branch;
    t_flash;
    t_back;
    t_stall;
    close_out;
  end
endmodule
